// ==== serial_mp_regs.sv ====
// apb register file, multiprocessor bit handling and bit-rate divisor of the serial unit
// What this block does
// - async multiprocessor reception stores each character's mp bit; read-only, resets to 0.
// - with receive disabled, the received mp flag keeps its previous value.
// - async transmission sends the transmit mp value as each character's mp bit.
// - transmit mp value ignored in sync mode, mp disabled, or when idle.
// - bit-rate divisor is 8-bit, readable and writable at any time.
// - divisor becomes ff on reset and is held at ff throughout low-power modes.
// - bit rate comes from divisor applied to prescaler-selected baud clock.
// - async bit rate is clock over 64 times 4^n times (n+1).
// - prescaler select 00,01,10,11 gives clock divided by 1,4,16,64.
// - sync bit rate is clock over 8 times 4^n times (n+1).
`timescale 1ns/1ps
module serial_mp_regs
   import serial_mp_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   // apb slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic [31:0]            prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // power controller: standby, watch, subactive or subsleep
   input  wire logic              low_power_i,
   // receive and transmit framers
   input  wire logic              rx_done_i,
   input  wire logic              rx_mp_bit_i,
   input  wire logic              tx_active_i,
   output logic                   tx_mp_bit_o,
   output logic                   rx_enable_o,
   output logic                   tx_enable_o,
   output logic                   sync_mode_o,
   output logic                   baud_tick_o,
   output logic                   bit_tick_o
);

   logic [1:0] rst_sync_q;
   logic       rst_n;
   apb_req_s   req;
   logic [3:0] wsel;
   logic       wr_en;
   logic [7:0] divisor_q;
   logic [7:0] format_q;
   logic [7:0] control_q;
   logic       tx_mp_value_q;
   logic       rx_mp_flag_q;
   logic       mp_active;
   logic       capture;

   // reset released through two flops so every register leaves reset on one edge
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i, addr: paddr_i,
                  wdata: pwdata_i};

   // one-hot register select; zero means unmapped
   function automatic logic [3:0] reg_decode(input logic [ADDR_W-1:0] a);
      unique case (a)
         OFS_DIVISOR: reg_decode = 4'b0001;
         OFS_FORMAT:  reg_decode = 4'b0010;
         OFS_CONTROL: reg_decode = 4'b0100;
         OFS_STATUS:  reg_decode = 4'b1000;
         default:     reg_decode = 4'b0000;
      endcase
   endfunction

   assign wsel      = reg_decode(req.addr);
   assign wr_en     = req.sel && req.enable && req.write;
   // zero wait states: read data is latched in setup, so the access cycle always completes
   assign pready_o  = req.sel && req.enable;

   // read data and error are captured in the setup cycle
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (req.sel && !req.enable) begin
         pslverr_o <= (wsel == 4'b0000);
         unique case (wsel)
            4'b0001: prdata_o <= {24'h00_0000, divisor_q};
            4'b0010: prdata_o <= {24'h00_0000, format_q};
            4'b0100: prdata_o <= {24'h00_0000, control_q};
            4'b1000: prdata_o <= {30'h0000_0000, rx_mp_flag_q, tx_mp_value_q};
            default: prdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // divisor: any-time access, forced to ff while the chip is in a low-power mode
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         divisor_q <= DIVISOR_RST;
      end else if (low_power_i) begin
         divisor_q <= DIVISOR_RST;
      end else if (wr_en && wsel[0]) begin
         divisor_q <= req.wdata[7:0];
      end
   end

   // mode and control words; all eight written bits are kept
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         format_q  <= FORMAT_RST;
         control_q <= CONTROL_RST;
      end else begin
         if (wr_en && wsel[1]) begin
            format_q <= req.wdata[7:0];
         end
         if (wr_en && wsel[2]) begin
            control_q <= req.wdata[7:0];
         end
      end
   end

   // transmit mp value is software-owned; the received flag ignores writes
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_mp_value_q <= 1'b0;
      end else if (wr_en && wsel[3]) begin
         tx_mp_value_q <= req.wdata[STS_TX_MP];
      end
   end

   assign mp_active   = format_q[FMT_MP_EN] && !format_q[FMT_SYNC];
   assign capture     = rx_done_i && mp_active && control_q[CTL_RX_EN];
   assign rx_enable_o = control_q[CTL_RX_EN];
   assign tx_enable_o = control_q[CTL_TX_EN];
   assign sync_mode_o = format_q[FMT_SYNC];

   // received mp flag: updated only by a completed async mp character
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rx_mp_flag_q <= 1'b0;
      end else if (capture) begin
         rx_mp_flag_q <= rx_mp_bit_i;
      end
   end

   // mp bit handed to the transmit framer; forced low whenever it has no meaning
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_mp_bit_o <= 1'b0;
      end else begin
         tx_mp_bit_o <= mp_active && tx_active_i && tx_mp_value_q;
      end
   end

   baud_gen u_baud_gen (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n),
      .halt_i      (low_power_i),
      .divisor_i   (divisor_q),
      .presc_sel_i ({format_q[FMT_PRESC_HI], format_q[FMT_PRESC_LO]}),
      .sync_mode_i (format_q[FMT_SYNC]),
      .baud_tick_o (baud_tick_o),
      .bit_tick_o  (bit_tick_o)
   );

   // ---- checks ----
   logic [15:0] gap_q;
   logic [1:0]  cfg_ok_q;
   logic [6:0]  bgap_q;
   logic [1:0]  bok_q;
   logic [15:0] expect_gap;
   logic [6:0]  expect_bits;
   logic        cfg_change;

   assign cfg_change  = low_power_i || (wr_en && (wsel[0] || wsel[1]));
   assign expect_gap  = (16'(divisor_q) + 16'h0001) << {format_q[FMT_PRESC_HI],
                                                      format_q[FMT_PRESC_LO], 1'b0};
   assign expect_bits = format_q[FMT_SYNC] ? 7'd8 : 7'd64;

   // cycles between baud ticks and baud ticks between bit ticks, valid after two clean ticks
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         gap_q    <= 16'h0000;
         cfg_ok_q <= 2'b00;
         bgap_q   <= 7'h00;
         bok_q    <= 2'b00;
      end else begin
         gap_q <= baud_tick_o ? 16'h0001 : gap_q + 16'h0001;
         if (cfg_change) begin
            cfg_ok_q <= 2'b00;
            bok_q    <= 2'b00;
         end else begin
            if (baud_tick_o && cfg_ok_q != 2'b10) cfg_ok_q <= cfg_ok_q + 2'b01;
            if (bit_tick_o && bok_q != 2'b10) bok_q <= bok_q + 2'b01;
         end
         if (bit_tick_o) bgap_q <= 7'h00;
         else if (baud_tick_o) bgap_q <= bgap_q + 7'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_div_write;
      wr_en && wsel[0] && !low_power_i;
   endsequence

   sequence s_div_read;
      req.sel && !req.enable && !req.write && wsel[0] ##1 req.sel && req.enable;
   endsequence

   mp_capture_a: assert property (capture |=> rx_mp_flag_q == $past(rx_mp_bit_i))
      else $error("received mp flag did not take the character's mp bit");
   mp_hold_a: assert property (!control_q[CTL_RX_EN] |=> $stable(rx_mp_flag_q))
      else $error("received mp flag changed while receive disabled");
   tx_mp_a: assert property (mp_active && tx_active_i
      |=> tx_mp_bit_o == $past(tx_mp_value_q))
      else $error("transmitted mp bit differs from the transmit mp value");
   tx_ignore_a: assert property (!mp_active || !tx_active_i |=> !tx_mp_bit_o)
      else $error("mp bit driven outside async mp transmission");
   div_write_a: assert property (s_div_write |=> divisor_q == $past(req.wdata[7:0]))
      else $error("divisor write not stored");
   div_read_a: assert property (s_div_read
      |-> prdata_o == {24'h00_0000, divisor_q} && pready_o)
      else $error("divisor read returned wrong data");
   div_sleep_a: assert property (low_power_i
      |=> divisor_q == DIVISOR_RST && !baud_tick_o)
      else $error("divisor not forced to ff in low-power mode");
   baud_period_a: assert property (baud_tick_o && cfg_ok_q == 2'b10
      |-> gap_q == expect_gap)
      else $error("baud period not (n+1) prescaled clocks");
   bit_period_a: assert property (bit_tick_o && bok_q == 2'b10
      |-> baud_tick_o && bgap_q == expect_bits - 7'd1)
      else $error("bit period not 64 or 8 baud periods");

endmodule

// ==== serial_mp_pkg.sv ====
// shared constants and carrier types for the multiprocessor-bit and bit-rate block
package serial_mp_pkg;

   // register word offsets on the apb bus (byte addresses)
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFS_DIVISOR     = 8'h00;
   localparam logic [7:0]  OFS_FORMAT      = 8'h04;
   localparam logic [7:0]  OFS_CONTROL     = 8'h08;
   localparam logic [7:0]  OFS_STATUS      = 8'h0c;

   // reset values
   localparam logic [7:0]  DIVISOR_RST     = 8'hff;
   localparam logic [7:0]  FORMAT_RST      = 8'h00;
   localparam logic [7:0]  CONTROL_RST     = 8'h00;

   // serial_format_register fields
   localparam int          FMT_PRESC_LO    = 0;
   localparam int          FMT_PRESC_HI    = 1;
   localparam int          FMT_MP_EN       = 2;
   localparam int          FMT_SYNC        = 7;

   // serial_control_word fields
   localparam int          CTL_RX_EN       = 4;
   localparam int          CTL_TX_EN       = 5;

   // status fields
   localparam int          STS_TX_MP       = 0;
   localparam int          STS_RX_MP       = 1;

   // baud generator ticks per serial bit, minus one
   localparam logic [5:0]  ASYNC_BIT_LAST  = 6'd63;
   localparam logic [5:0]  SYNC_BIT_LAST   = 6'd7;

   // one apb request as seen by the slave
   typedef struct packed {
      logic              sel;
      logic              enable;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
   } apb_req_s;

endpackage

// ==== baud_gen.sv ====
// prescaler, baud rate counter and bit-rate post divider
`timescale 1ns/1ps
module baud_gen
   import serial_mp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       halt_i,
   input  wire logic [7:0] divisor_i,
   input  wire logic [1:0] presc_sel_i,
   input  wire logic       sync_mode_i,
   output logic            baud_tick_o,
   output logic            bit_tick_o
);

   logic [5:0] presc_q;
   logic [7:0] count_q;
   logic [5:0] post_q;
   logic       presc_tick;
   logic       expire;
   logic [5:0] post_last;

   // prescaled clock enable: every 1, 4, 16 or 64 system clocks
   function automatic logic presc_hit(input logic [1:0] sel, input logic [5:0] cnt);
      unique case (sel)
         2'b00: presc_hit = 1'b1;
         2'b01: presc_hit = &cnt[1:0];
         2'b10: presc_hit = &cnt[3:0];
         2'b11: presc_hit = &cnt[5:0];
      endcase
   endfunction

   assign presc_tick = presc_hit(presc_sel_i, presc_q);
   assign expire     = presc_tick && (count_q == 8'h00);
   assign post_last  = sync_mode_i ? SYNC_BIT_LAST : ASYNC_BIT_LAST;

   // free-running prescaler; held at zero while the chip sleeps
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         presc_q <= 6'h00;
      end else if (halt_i) begin
         presc_q <= 6'h00;
      end else begin
         presc_q <= presc_q + 6'h01;
      end
   end

   // down counter of n+1 prescaled ticks, reloaded from the divisor on expiry
   // a divisor written mid-count takes effect at the next reload, so no period is cut short
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q     <= DIVISOR_RST;
         baud_tick_o <= 1'b0;
      end else if (halt_i) begin
         count_q     <= DIVISOR_RST;
         baud_tick_o <= 1'b0;
      end else begin
         baud_tick_o <= expire;
         if (expire) begin
            count_q <= divisor_i;
         end else if (presc_tick) begin
            count_q <= count_q - 8'h01;
         end
      end
   end

   // post divider: 64 baud periods per bit in async mode, 8 in sync mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         post_q     <= 6'h00;
         bit_tick_o <= 1'b0;
      end else if (halt_i) begin
         post_q     <= 6'h00;
         bit_tick_o <= 1'b0;
      end else begin
         bit_tick_o <= expire && (post_q >= post_last);
         if (expire) begin
            post_q <= (post_q >= post_last) ? 6'h00 : post_q + 6'h01;
         end
      end
   end

endmodule

// ==== framer_model.sv ====
// behavioural model of the receive and transmit framers beside the block
`timescale 1ns/1ps
module framer_model (
   input  wire logic clk_i,
   output logic      rx_done_o,
   output logic      rx_mp_bit_o,
   output logic      tx_active_o
);
   initial begin
      rx_done_o   = 1'b0;
      rx_mp_bit_o = 1'b0;
      tx_active_o = 1'b0;
   end

   // one finished character; the mp bit flips after the pulse so stale values show
   task automatic rx_char(input logic mp);
      @(posedge clk_i);
      rx_done_o   <= 1'b1;
      rx_mp_bit_o <= mp;
      @(posedge clk_i);
      rx_done_o   <= 1'b0;
      rx_mp_bit_o <= ~mp;
   endtask

   // transmit framer busy level
   task automatic tx_set(input logic act);
      @(posedge clk_i);
      tx_active_o <= act;
   endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the mp bit and bit-rate register block
`timescale 1ns/1ps
module testbench;
   import serial_mp_pkg::*;
   logic        clk;
   logic        arst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        low_power;
   logic        rx_done;
   logic        rx_mp;
   logic        tx_act;
   logic        tx_mp;
   logic        baud_tick;
   logic        bit_tick;
   logic        rx_en;
   logic        tx_en;
   logic        sync_m;
   int          miscompares;
   int          checked;

   serial_mp_regs dut (.clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .low_power_i(low_power),
      .rx_done_i(rx_done), .rx_mp_bit_i(rx_mp), .tx_active_i(tx_act),
      .tx_mp_bit_o(tx_mp), .rx_enable_o(rx_en), .tx_enable_o(tx_en), .sync_mode_o(sync_m),
      .baud_tick_o(baud_tick), .bit_tick_o(bit_tick));
   framer_model peer (.clk_i(clk), .rx_done_o(rx_done), .rx_mp_bit_o(rx_mp),
      .tx_active_o(tx_act));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic summarize;
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // pin levels are sampled pre-edge, i.e. the value held in the last cycle
   task automatic chk_pin(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no wait-state count is assumed; only the watchdog ends a hung access
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, a, d, rd, err);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      xfer(1'b0, a, 32'h0, rd, err);
      chk_val(rd, exp);
   endtask

   // cycles between ticks; the first two ticks after a change are skipped
   task automatic gap(input logic use_bit, output logic [31:0] n);
      repeat (3) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (!(use_bit ? bit_tick : baud_tick) && n < 20000);
      end
   endtask

   task automatic t_reset;
      logic [31:0] rd;
      logic        err;
      rd_chk(OFS_DIVISOR, 32'h0000_00ff);
      rd_chk(OFS_STATUS, 32'h0);
      xfer(1'b0, 8'h10, 32'h0, rd, err);
      chk_val(rd, 32'h0);
      chk_pin(err, 1'b1);
   endtask

   task automatic t_divisor;
      wr(OFS_DIVISOR, 32'h5a);
      rd_chk(OFS_DIVISOR, 32'h5a);
      wr(OFS_DIVISOR, 32'h00);
      rd_chk(OFS_DIVISOR, 32'h00);
      wr(OFS_STATUS, 32'h2);
      rd_chk(OFS_STATUS, 32'h0);
   endtask

   task automatic t_low_power;
      wr(OFS_DIVISOR, 32'h12);
      @(posedge clk);
      low_power <= 1'b1;
      rd_chk(OFS_DIVISOR, 32'hff);
      wr(OFS_DIVISOR, 32'h34);
      rd_chk(OFS_DIVISOR, 32'hff);
      @(posedge clk);
      low_power <= 1'b0;
      rd_chk(OFS_DIVISOR, 32'hff);
   endtask

   task automatic t_rx_mp;
      wr(OFS_FORMAT, 32'h1 << FMT_MP_EN);
      wr(OFS_CONTROL, 32'h1 << CTL_RX_EN);
      @(posedge clk);
      chk_pin(rx_en, 1'b1);
      peer.rx_char(1'b1);
      rd_chk(OFS_STATUS, 32'h2);
      peer.rx_char(1'b0);
      rd_chk(OFS_STATUS, 32'h0);
      peer.rx_char(1'b1);
      wr(OFS_CONTROL, 32'h0);
      @(posedge clk);
      chk_pin(rx_en, 1'b0);
      peer.rx_char(1'b0);
      rd_chk(OFS_STATUS, 32'h2);
      // transmit enable is a plain stored bit handed to the framer
      wr(OFS_CONTROL, 32'h1 << CTL_TX_EN);
      @(posedge clk);
      chk_pin(tx_en, 1'b1);
      chk_pin(rx_en, 1'b0);
      rd_chk(OFS_CONTROL, 32'h20);
   endtask

   // tx mp bit follows one cycle after its inputs settle
   task automatic tx_look(input logic exp);
      repeat (3) @(posedge clk);
      chk_pin(tx_mp, exp);
   endtask

   task automatic t_tx_mp;
      wr(OFS_STATUS, 32'h1);
      peer.tx_set(1'b1);
      tx_look(1'b1);
      wr(OFS_STATUS, 32'h0);
      tx_look(1'b0);
      wr(OFS_STATUS, 32'h1);
      wr(OFS_FORMAT, (32'h1 << FMT_MP_EN) | (32'h1 << FMT_SYNC));
      tx_look(1'b0);
      wr(OFS_FORMAT, 32'h0);
      tx_look(1'b0);
      wr(OFS_FORMAT, 32'h1 << FMT_MP_EN);
      peer.tx_set(1'b0);
      tx_look(1'b0);
   endtask

   task automatic t_baud;
      logic [31:0] n;
      wr(OFS_DIVISOR, 32'h1);
      for (int s = 0; s < 4; s++) begin
         wr(OFS_FORMAT, 32'(s));
         gap(1'b0, n);
         chk_val(n, 32'd2 << (2 * s));
      end
      wr(OFS_FORMAT, 32'h0);
      gap(1'b1, n);
      chk_val(n, 32'd128);
      chk_pin(sync_m, 1'b0);
      wr(OFS_FORMAT, 32'h1 << FMT_SYNC);
      gap(1'b1, n);
      chk_val(n, 32'd16);
      chk_pin(sync_m, 1'b1);
   endtask

   // watchdog sized well above the longest scenario
   initial begin
      #(25ns * 60000);
      miscompares++;
      summarize();
   end

   initial begin
      miscompares = 0;
      checked = 0;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      low_power = 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_divisor();
      t_low_power();
      t_rx_mp();
      t_tx_mp();
      t_baud();
      summarize();
   end
endmodule
